// [include/nmpc_regs.vh]
`ifndef NMPC_REGS_VH
`define NMPC_REGS_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define NMPC_OFF_CTRL 12'h000
`define NMPC_OFF_HDIV 12'h004
`define NMPC_OFF_NDIV 12'h008
`define NMPC_OFF_STAT 12'h00C
`define NMPC_OFF_ISTAT 12'h010
`define NMPC_OFF_IMASK 12'h014
`define NMPC_OFF_MAP 12'h020
// ************************************************************
// fields and reset values
// ************************************************************
`define NMPC_CTRL_RESTART 8
`define NMPC_IRQ_TO 0
`define NMPC_IRQ_INIT 1
`define NMPC_IRQ_DROP 2
`define NMPC_IRQ_OVF 3
`define NMPC_HDIV_RST 16'h0823
`define NMPC_NDIV_RST 16'h0823
// ************************************************************
// timing
// ************************************************************
`define NMPC_CLK_HZ 20000000
`define NMPC_SVC_BAUD 9600
`define NMPC_SVC_DIV (`NMPC_CLK_HZ / `NMPC_SVC_BAUD)
`define NMPC_RESP_TO_US 10000
// ************************************************************
// addresses and characters
// ************************************************************
`define NMPC_MASTER_ADDR 7'h00
`define NMPC_MAX_ADDR 7'h63
`define NMPC_CH_STX 8'h02
`define NMPC_CH_CR 8'h0D
`define NMPC_CH_LF 8'h0A
`define NMPC_CH_ZERO 8'h30
`define NMPC_CH_T 8'h54
`endif

// [hw/nmpc_uart_rx.v]
`timescale 1ns/100ps
module nmpc_uart_rx (
	input wire core_clk,
	input wire resetn,
	input wire [15:0] div,
	input wire rxd,
	output reg [7:0] data,
	output reg valid
);
	reg busy;
	reg [15:0] cnt;
	reg [3:0] bitn;
	reg [7:0] sh;

	// 8 data bits, one stop bit, no parity; samples mid-bit
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			cnt <= 16'h0000;
			bitn <= 4'h0;
			sh <= 8'h00;
			data <= 8'h00;
			valid <= 1'b0;
		end else begin
			valid <= 1'b0;
			if (!busy) begin
				if (!rxd) begin
					busy <= 1'b1;
					cnt <= {1'b0, div[15:1]};
					bitn <= 4'h0;
				end
			end else if (cnt != 16'h0000) begin
				cnt <= cnt - 16'h0001;
			end else begin
				cnt <= div - 16'h0001;
				bitn <= bitn + 4'h1;
				if (bitn == 4'h0) begin
					if (rxd)
						busy <= 1'b0;
				end else if (bitn == 4'h9) begin
					busy <= 1'b0;
					if (rxd) begin
						data <= sh;
						valid <= 1'b1;
					end
				end else begin
					sh <= {rxd, sh[7:1]};
				end
			end
		end
	end
endmodule

// [hw/nmpc_uart_tx.v]
`timescale 1ns/100ps
module nmpc_uart_tx (
	input wire core_clk,
	input wire resetn,
	input wire [15:0] div,
	input wire [7:0] data,
	input wire start,
	output reg busy,
	output reg txd
);
	reg [15:0] cnt;
	reg [3:0] bitn;
	reg [8:0] sh;

	// start is taken only while busy is low
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			txd <= 1'b1;
			cnt <= 16'h0000;
			bitn <= 4'h0;
			sh <= 9'h1FF;
		end else if (!busy) begin
			if (start) begin
				busy <= 1'b1;
				txd <= 1'b0;
				sh <= {1'b1, data};
				cnt <= div - 16'h0001;
				bitn <= 4'h0;
			end
		end else if (cnt != 16'h0000) begin
			cnt <= cnt - 16'h0001;
		end else begin
			cnt <= div - 16'h0001;
			bitn <= bitn + 4'h1;
			if (bitn == 4'h9) begin
				busy <= 1'b0;
			end else begin
				txd <= sh[0];
				sh <= {1'b1, sh[8:1]};
			end
		end
	end
endmodule

// [hw/nmpc_top.v]
// Overview of operation
// - master is address zero; switch never sets own address, zero never forwarded.
// - address switch value is the highest slave address polled.
// - after reset, probe every slave from one to highest address; code reads the switch as zero at reset exit and probes only after restart.
// - unanswered probe sends two address digits then T to the active port (host, or service port in service mode).
// - after time-outs the master keeps running and serves answering slaves.
// - timed-out slaves are marked inaccessible; frames to them are dropped.
// - third switch on selects service mode for commands from service port.
// - service switch off: service port only mirrors, its input is dropped.
// - in service mode host port is disconnected, service port is sole path.
// - service mode uses fixed 9600 baud, 8 data bits, 1 stop.
// - service port has no parity and no handshake lines.
// - frame is STX, two address digits, payload, CR, LF.
// - address is two ASCII decimal digits, high first, naming the slave.
// - switching back to host reconnects host port without reset.
// - host position: service port copies host transmit line unchanged.
// - outside service mode host port commands go to addressed slaves.
// - software highest address used only when the switch reads zero.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "nmpc_regs.vh"
module nmpc_top #(
	parameter [31:0] RESP_TO_CYC = `NMPC_RESP_TO_US * (`NMPC_CLK_HZ / 1000000)
) (
	input wire core_clk,
	input wire resetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	output wire irq,
	input wire [6:0] addr_sw,
	input wire svc_sw,
	input wire host_rxd,
	output wire host_txd,
	input wire svc_rxd,
	output reg svc_txd,
	input wire net_rxd,
	output wire net_txd,
	output wire net_oe_n,
	output reg net_ok
);
	localparam [31:0] SVC_DIV_W = `NMPC_SVC_DIV;
	localparam [15:0] SVC_DIV = SVC_DIV_W[15:0];
	localparam [4:0] P_START = 5'h01, P_PROBE = 5'h02, P_WAIT = 5'h04;
	localparam [4:0] P_REPORT = 5'h08, P_DONE = 5'h10;
	localparam [4:0] C_IDLE = 5'h01, C_HI = 5'h02, C_LO = 5'h04;
	localparam [4:0] C_HDR = 5'h08, C_BODY = 5'h10;

	// ************************************************************
	// helpers
	// ************************************************************
	function [15:0] nmpc_digits;
		input [6:0] n;
		reg [6:0] t;
		begin
			t = n / 7'd10;
			nmpc_digits = {`NMPC_CH_ZERO + {1'b0, t}, `NMPC_CH_ZERO + {1'b0, n - t * 7'd10}};
		end
	endfunction

	function [7:0] nmpc_addr;
		input [7:0] hi;
		input [7:0] lo;
		reg [7:0] hd;
		reg [7:0] ld;
		begin
			hd = hi - `NMPC_CH_ZERO;
			ld = lo - `NMPC_CH_ZERO;
			nmpc_addr = {(hd < 8'h0A) && (ld < 8'h0A), hd[6:0] * 7'd10 + ld[6:0]};
		end
	endfunction

	function [6:0] nmpc_clamp;
		input [6:0] n;
		begin
			nmpc_clamp = (n > `NMPC_MAX_ADDR) ? `NMPC_MAX_ADDR : n;
		end
	endfunction

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	reg [10:0] pin_s1;
	reg [10:0] pin_s2;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= 11'h007;
			pin_s2 <= 11'h007;
		end else begin
			pin_s1 <= {addr_sw, svc_sw, host_rxd, svc_rxd, net_rxd};
			pin_s2 <= pin_s1;
		end
	end
	wire [6:0] sw_addr = pin_s2[10:4];
	wire svc_mode = pin_s2[3];

	// ************************************************************
	// registers and APB
	// ************************************************************
	reg [6:0] sw_last;
	reg [15:0] host_div;
	reg [15:0] net_div;
	reg [3:0] istat;
	reg [3:0] imask;
	reg [127:0] alive_map;
	reg [6:0] last_addr;
	reg any_to;
	reg [4:0] pstate;
	reg [31:0] rd_mux;
	reg rd_hit;
	wire wr = psel & penable & pwrite;
	wire restart = wr && (paddr == `NMPC_OFF_CTRL) && pwdata[`NMPC_CTRL_RESTART];
	wire [3:0] ev;
	assign pready = 1'b1;
	assign irq = |(istat & imask);

	always @* begin
		rd_hit = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`NMPC_OFF_CTRL: rd_mux = {25'h0000000, sw_last};
			`NMPC_OFF_HDIV: rd_mux = {16'h0000, host_div};
			`NMPC_OFF_NDIV: rd_mux = {16'h0000, net_div};
			`NMPC_OFF_STAT: rd_mux = {17'h00000, last_addr, 5'h00, any_to, svc_mode,
				pstate == P_DONE};
			`NMPC_OFF_ISTAT: rd_mux = {28'h0000000, istat};
			`NMPC_OFF_IMASK: rd_mux = {28'h0000000, imask};
			12'h020: rd_mux = alive_map[31:0];
			12'h024: rd_mux = alive_map[63:32];
			12'h028: rd_mux = alive_map[95:64];
			12'h02C: rd_mux = alive_map[127:96];
			default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			sw_last <= 7'h00;
			host_div <= `NMPC_HDIV_RST;
			net_div <= `NMPC_NDIV_RST;
			imask <= 4'h0;
			istat <= 4'h0;
		end else begin
			if (psel && !penable) begin
				prdata <= rd_mux;
				pslverr <= !rd_hit;
			end
			if (wr && paddr == `NMPC_OFF_CTRL)
				sw_last <= pwdata[6:0];
			if (wr && paddr == `NMPC_OFF_HDIV)
				host_div <= pwdata[15:0];
			if (wr && paddr == `NMPC_OFF_NDIV)
				net_div <= pwdata[15:0];
			if (wr && paddr == `NMPC_OFF_IMASK)
				imask <= pwdata[3:0];
			// new events win over a write-one clear
			istat <= (istat & ~((wr && paddr == `NMPC_OFF_ISTAT) ? pwdata[3:0] : 4'h0)) | ev;
		end
	end

	// ************************************************************
	// serial ports
	// ************************************************************
	wire [7:0] host_rx_data;
	wire host_rx_valid;
	wire [7:0] svc_rx_data;
	wire svc_rx_valid;
	wire [7:0] net_rx_data;
	wire net_rx_valid;
	wire host_busy;
	wire svc_busy;
	wire svc_tx_line;
	wire net_busy;
	reg out_start;
	reg [7:0] out_data;
	reg net_start;
	reg [7:0] net_data;
	wire out_busy = svc_mode ? svc_busy : host_busy;

	nmpc_uart_rx u_host_rx (.core_clk(core_clk), .resetn(resetn), .div(host_div),
		.rxd(pin_s2[2]), .data(host_rx_data), .valid(host_rx_valid));
	nmpc_uart_rx u_svc_rx (.core_clk(core_clk), .resetn(resetn), .div(SVC_DIV),
		.rxd(pin_s2[1]), .data(svc_rx_data), .valid(svc_rx_valid));
	nmpc_uart_rx u_net_rx (.core_clk(core_clk), .resetn(resetn), .div(net_div),
		.rxd(pin_s2[0]), .data(net_rx_data), .valid(net_rx_valid));
	// host transmitter silent in service mode
	nmpc_uart_tx u_host_tx (.core_clk(core_clk), .resetn(resetn), .div(host_div),
		.data(out_data), .start(out_start & !svc_mode), .busy(host_busy), .txd(host_txd));
	nmpc_uart_tx u_svc_tx (.core_clk(core_clk), .resetn(resetn), .div(SVC_DIV),
		.data(out_data), .start(out_start & svc_mode), .busy(svc_busy), .txd(svc_tx_line));
	nmpc_uart_tx u_net_tx (.core_clk(core_clk), .resetn(resetn), .div(net_div),
		.data(net_data), .start(net_start), .busy(net_busy), .txd(net_txd));
	assign net_oe_n = ~net_busy;

	// monitor copies host line bit for bit outside service mode
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			svc_txd <= 1'b1;
		else
			svc_txd <= svc_mode ? svc_tx_line : host_txd;
	end

	// ************************************************************
	// start-up polling
	// ************************************************************
	reg [6:0] poll_addr;
	reg [2:0] pidx;
	reg [31:0] timer;
	reg got_reply;
	reg to_ev;
	reg init_ev;
	reg ovf_ev;
	reg drop_ev;
	reg [7:0] rp_data;
	reg rp_full;
	wire [15:0] poll_dig = nmpc_digits(poll_addr);
	wire poll_last = (poll_addr == last_addr);
	wire done = (pstate == P_DONE);
	assign ev = {ovf_ev, drop_ev, init_ev, to_ev};

	always @* begin
		out_start = 1'b0;
		out_data = rp_data;
		if (pstate == P_REPORT && !out_busy) begin
			out_start = 1'b1;
			case (pidx)
				3'h0: out_data = poll_dig[15:8];
				3'h1: out_data = poll_dig[7:0];
				default: out_data = `NMPC_CH_T;
			endcase
		end else if (done && rp_full && !out_busy) begin
			out_start = 1'b1;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pstate <= P_START;
			poll_addr <= 7'h01;
			last_addr <= 7'h00;
			pidx <= 3'h0;
			timer <= 32'h00000000;
			got_reply <= 1'b0;
			alive_map <= 128'h0;
			any_to <= 1'b0;
			to_ev <= 1'b0;
			init_ev <= 1'b0;
			net_ok <= 1'b0;
		end else begin
			to_ev <= 1'b0;
			init_ev <= 1'b0;
			net_ok <= done && !any_to;
			case (pstate)
				P_START: begin
					// software value only when switch is zero
					last_addr <= (sw_addr != 7'h00) ? nmpc_clamp(sw_addr) : nmpc_clamp(sw_last);
					// probing skips the master's own address
					poll_addr <= `NMPC_MASTER_ADDR + 7'h01;
					pidx <= 3'h0;
					alive_map <= 128'h0;
					any_to <= 1'b0;
					if (sw_addr == 7'h00 && sw_last == 7'h00) begin
						pstate <= P_DONE;
						init_ev <= 1'b1;
					end else begin
						pstate <= P_PROBE;
					end
				end
				P_PROBE: begin
					if (!net_busy) begin
						pidx <= pidx + 3'h1;
						if (pidx == 3'h4) begin
							pidx <= 3'h0;
							timer <= 32'h00000000;
							got_reply <= 1'b0;
							pstate <= P_WAIT;
						end
					end
				end
				P_WAIT: begin
					timer <= timer + 32'h00000001;
					if (net_rx_valid)
						got_reply <= 1'b1;
					if ((net_rx_valid && net_rx_data == `NMPC_CH_LF) ||
						(timer == RESP_TO_CYC - 32'h00000001 && got_reply)) begin
						alive_map[poll_addr] <= 1'b1;
						pidx <= 3'h0;
						if (poll_last) begin
							pstate <= P_DONE;
							init_ev <= 1'b1;
						end else begin
							poll_addr <= poll_addr + 7'h01;
							pstate <= P_PROBE;
						end
					end else if (timer == RESP_TO_CYC - 32'h00000001) begin
						to_ev <= 1'b1;
						any_to <= 1'b1;
						pidx <= 3'h0;
						pstate <= P_REPORT;
					end
				end
				P_REPORT: begin
					if (!out_busy) begin
						pidx <= pidx + 3'h1;
						if (pidx == 3'h2) begin
							pidx <= 3'h0;
							if (poll_last) begin
								pstate <= P_DONE;
								init_ev <= 1'b1;
							end else begin
								poll_addr <= poll_addr + 7'h01;
								pstate <= P_PROBE;
							end
						end
					end
				end
				P_DONE: begin
					if (restart)
						pstate <= P_START;
				end
				default: pstate <= P_START;
			endcase
		end
	end

	// network answers after start-up go to the active port
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rp_data <= 8'h00;
			rp_full <= 1'b0;
		end else if (done && net_rx_valid) begin
			rp_data <= net_rx_data;
			rp_full <= 1'b1;
		end else if (out_start && pstate == P_DONE) begin
			rp_full <= 1'b0;
		end
	end

	// ************************************************************
	// command framing and forwarding
	// ************************************************************
	reg [4:0] cstate;
	reg [7:0] hi_ch;
	reg [7:0] lo_ch;
	reg [1:0] hidx;
	reg fwd;
	reg svc_mode_q;
	reg [7:0] q_mem [0:7];
	reg [3:0] wp;
	reg [3:0] rp;
	reg q_push;
	reg [7:0] q_wdata;
	// service input dropped in host position
	// host commands taken only outside service mode
	wire cmd_valid = done && (svc_mode ? svc_rx_valid : host_rx_valid);
	wire [7:0] cmd_data = svc_mode ? svc_rx_data : host_rx_data;
	wire [7:0] dec = nmpc_addr(hi_ch, cmd_data);
	wire q_empty = (wp == rp);
	wire q_full = (wp[2:0] == rp[2:0]) && (wp[3] != rp[3]);
	// two decimal digits name the slave
	// address zero is the master and never forwarded
	// frames to inaccessible slaves are dropped
	wire dest_ok = dec[7] && (dec[6:0] != `NMPC_MASTER_ADDR) && (dec[6:0] <= last_addr) &&
		alive_map[dec[6:0]];

	always @* begin
		q_push = 1'b0;
		q_wdata = cmd_data;
		if (cstate == C_HDR) begin
			q_push = 1'b1;
			case (hidx)
				2'h0: q_wdata = `NMPC_CH_STX;
				2'h1: q_wdata = hi_ch;
				default: q_wdata = lo_ch;
			endcase
		end else if (cstate == C_BODY && cmd_valid && fwd && cmd_data != `NMPC_CH_STX) begin
			q_push = 1'b1;
		end
		net_start = 1'b0;
		net_data = q_mem[rp[2:0]];
		if (pstate == P_PROBE && !net_busy) begin
			net_start = 1'b1;
			case (pidx)
				3'h0: net_data = `NMPC_CH_STX;
				3'h1: net_data = poll_dig[15:8];
				3'h2: net_data = poll_dig[7:0];
				3'h3: net_data = `NMPC_CH_CR;
				default: net_data = `NMPC_CH_LF;
			endcase
		end else if (done && !q_empty && !net_busy) begin
			net_start = 1'b1;
		end
	end

	always @(posedge core_clk) begin
		if (q_push && !q_full)
			q_mem[wp[2:0]] <= q_wdata;
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cstate <= C_IDLE;
			hi_ch <= 8'h00;
			lo_ch <= 8'h00;
			hidx <= 2'h0;
			fwd <= 1'b0;
			svc_mode_q <= 1'b0;
			wp <= 4'h0;
			rp <= 4'h0;
			ovf_ev <= 1'b0;
			drop_ev <= 1'b0;
		end else begin
			svc_mode_q <= svc_mode;
			ovf_ev <= q_push && q_full;
			drop_ev <= 1'b0;
			if (q_push && !q_full)
				wp <= wp + 4'h1;
			if (net_start && pstate == P_DONE)
				rp <= rp + 4'h1;
			// source change restarts framing, no reset needed
			if (svc_mode != svc_mode_q || !done) begin
				cstate <= C_IDLE;
			end else begin
				case (cstate)
					C_IDLE: if (cmd_valid && cmd_data == `NMPC_CH_STX) cstate <= C_HI;
					C_HI: begin
						if (cmd_valid) begin
							hi_ch <= cmd_data;
							cstate <= C_LO;
						end
					end
					C_LO: begin
						if (cmd_valid) begin
							lo_ch <= cmd_data;
							hidx <= 2'h0;
							fwd <= 1'b0;
							cstate <= dest_ok ? C_HDR : C_BODY;
							drop_ev <= !dest_ok;
						end
					end
					C_HDR: begin
						hidx <= hidx + 2'h1;
						if (hidx == 2'h2) begin
							fwd <= 1'b1;
							cstate <= C_BODY;
						end
					end
					C_BODY: begin
						if (cmd_valid && cmd_data == `NMPC_CH_LF)
							cstate <= C_IDLE;
						else if (cmd_valid && cmd_data == `NMPC_CH_STX)
							cstate <= C_HI;
					end
					default: cstate <= C_IDLE;
				endcase
			end
		end
	end
endmodule

// [sim/nmpc_sva.sv]
`timescale 1ns/100ps
module nmpc_sva #(
	parameter [31:0] RESP_TO_CYC = 32'h7D0
) (
	input wire core_clk,
	input wire resetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire irq,
	input wire svc_sw,
	input wire host_txd,
	input wire svc_txd,
	input wire net_txd,
	input wire net_oe_n
);
	// ************************************************************
	// helpers
	// ************************************************************
	wire lo_ok = paddr <= 12'h014;
	wire map_ok = paddr >= 12'h020 && paddr <= 12'h02C;
	wire unm = !((lo_ok || map_ok) && paddr[1:0] == 2'h0);
	reg [3:0] mask_q;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mask_q <= 4'h0;
		end else if (psel && penable && pwrite && paddr == 12'h014) begin
			mask_q <= pwdata[3:0];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_host_mode;
		!svc_sw [*5];
	endsequence
	// ************************************************************
	// properties
	// ************************************************************
	chk_err_unmapped: assert property (s_setup ##0 unm |=> pslverr)
		else $error("unmapped access without error");
	chk_err_mapped: assert property (s_setup ##0 !unm |=> !pslverr)
		else $error("mapped access with error");
	chk_rd_zero: assert property (s_setup ##0 (unm && !pwrite) |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_ctrl_width: assert property (s_setup ##0 (paddr == 12'h000 && !pwrite)
		|=> prdata[31:7] == 25'h0) else $error("control read wider than field");
	chk_data_hold: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
		else $error("read data changed outside setup");
	chk_irq_masked: assert property (mask_q == 4'h0 |-> !irq)
		else $error("interrupt with all masked");
	chk_mirror_host: assert property (s_host_mode |=> svc_txd == $past(host_txd))
		else $error("service port not mirroring host");
	chk_net_idle: assert property (net_oe_n |-> net_txd)
		else $error("network line low while not driven");
endmodule
bind nmpc_top nmpc_sva #(.RESP_TO_CYC(RESP_TO_CYC)) sva_u (.core_clk(core_clk),
	.resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .irq(irq), .svc_sw(svc_sw),
	.host_txd(host_txd), .svc_txd(svc_txd), .net_txd(net_txd), .net_oe_n(net_oe_n));

// [sim/nmpc_slave_model.sv]
`timescale 1ns/100ps
module nmpc_slave_model #(
	parameter int DIV = 16,
	parameter logic [127:0] ALIVE = 128'hA
) (
	input wire core_clk,
	input wire resetn,
	input wire net_txd,
	output logic net_rxd,
	output logic [15:0] frames,
	output logic [6:0] last_addr
);
	logic [7:0] b;
	logic [7:0] hi;
	logic [7:0] lo;
	logic [9:0] f;
	int st;
	int a;
	initial begin
		net_rxd = 1'h1;
		frames = 16'h0;
		last_addr = 7'h0;
		st = 0;
		forever begin
			@(posedge core_clk);
			if (resetn === 1'h1 && net_txd === 1'h0) begin
				repeat (DIV / 2) @(posedge core_clk);
				for (int i = 0; i < 8; i++) begin
					repeat (DIV) @(posedge core_clk);
					b[i] = net_txd;
				end
				repeat (DIV) @(posedge core_clk);
				if (b == 8'h02) begin
					st = 1;
				end else if (st == 1) begin
					hi = b;
					st = 2;
				end else if (st == 2) begin
					lo = b;
					st = 3;
				end else if (st == 3 && b == 8'h0A) begin
					st = 0;
					a = (hi - 8'h30) * 10 + (lo - 8'h30);
					frames <= frames + 16'h1;
					last_addr <= a[6:0];
					if (a >= 0 && a < 128 && ALIVE[a]) begin
						f = {1'h1, 8'h0A, 1'h0};
						for (int i = 0; i < 10; i++) begin
							net_rxd <= f[i];
							repeat (DIV) @(posedge core_clk);
						end
					end
				end
			end
		end
	end
endmodule

// [sim/nmpc_top_tb.sv]
`timescale 1ns/100ps
`include "nmpc_regs.vh"
module nmpc_top_tb;
	localparam int DIV = 16;
	logic core_clk, resetn, psel, penable, pwrite, svc_sw, host_rxd, svc_rxd, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [6:0] addr_sw;
	logic [7:0] host_q[$];
	logic [15:0] bad[3] = '{16'h3032, 16'h3030, 16'h3133};
	wire [31:0] prdata;
	wire pready, pslverr, irq, host_txd, svc_txd, net_rxd, net_txd, net_oe_n, net_ok;
	wire [15:0] frames;
	wire [6:0] last_addr;
	int error_cnt = 0;
	int num_checks = 0;
	nmpc_top #(.RESP_TO_CYC(32'h7D0)) dut_u (.core_clk(core_clk), .resetn(resetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .addr_sw(addr_sw),
		.svc_sw(svc_sw), .host_rxd(host_rxd), .host_txd(host_txd), .svc_rxd(svc_rxd),
		.svc_txd(svc_txd), .net_rxd(net_rxd), .net_txd(net_txd), .net_oe_n(net_oe_n),
		.net_ok(net_ok));
	nmpc_slave_model #(.DIV(DIV), .ALIVE(128'hA)) slv_u (.core_clk(core_clk),
		.resetn(resetn), .net_txd(net_txd), .net_rxd(net_rxd), .frames(frames),
		.last_addr(last_addr));
	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50) begin
			cmp(0, 1, "bus hang");
			wrap_up();
		end
	endtask
	task automatic tx_byte(input logic svc, input logic [7:0] b);
		logic [9:0] f;
		int bt;
		f = {1'h1, b, 1'h0};
		// service port runs at its fixed rate
		bt = svc ? `NMPC_SVC_DIV : DIV;
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			if (svc) begin
				svc_rxd <= f[i];
			end else begin
				host_rxd <= f[i];
			end
			repeat (bt - 1) @(posedge core_clk);
		end
	endtask
	task automatic send_frame(input logic svc, input logic [15:0] ad);
		tx_byte(svc, 8'h02);
		tx_byte(svc, ad[15:8]);
		tx_byte(svc, ad[7:0]);
		tx_byte(svc, 8'h41);
		tx_byte(svc, 8'h0D);
		tx_byte(svc, 8'h0A);
	endtask
	task automatic wait_frames(input logic [15:0] exp, input string what);
		for (int n = 0; n < 3000 && frames !== exp; n++) @(posedge core_clk);
		cmp(frames, exp, what);
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			repeat (100) @(posedge core_clk);
			apb(1'h0, 12'h00C, 32'h0);
			n++;
		end while (rd[0] !== 1'h1 && n < 300);
		if (n >= 300) begin
			cmp(0, 1, "polling hang");
			wrap_up();
		end
	endtask
	initial begin
		host_q.push_back(8'h0);
		host_q.delete();
		forever begin
			@(posedge core_clk);
			if (resetn === 1'h1 && host_txd === 1'h0) begin
				logic [7:0] b;
				repeat (DIV / 2) @(posedge core_clk);
				for (int i = 0; i < 8; i++) begin
					repeat (DIV) @(posedge core_clk);
					b[i] = host_txd;
				end
				repeat (DIV) @(posedge core_clk);
				host_q.push_back(b);
			end
		end
	end
	task automatic t_regs();
		apb(1'h0, 12'h004, 32'h0);
		cmp(rd, 32'h0823, "hdiv reset");
		apb(1'h0, 12'h008, 32'h0);
		cmp(rd, 32'h0823, "ndiv reset");
		apb(1'h0, 12'h018, 32'h0);
		cmp({31'h0, err}, 32'h1, "unmapped error");
		cmp(rd, 32'h0, "unmapped read");
		wait_done();
		cmp(rd[14:8], 7'h0, "last addr sw zero");
		$display("t_regs done");
	endtask
	task automatic t_poll();
		addr_sw <= 7'h03;
		apb(1'h1, 12'h004, 32'h10);
		apb(1'h1, 12'h008, 32'h10);
		apb(1'h1, 12'h014, 32'h1);
		apb(1'h1, 12'h000, 32'h105);
		wait_done();
		cmp(rd[14:8], 7'h03, "last addr");
		cmp(rd[2], 1'h1, "timeout flag");
		cmp(frames, 16'h3, "probe count");
		apb(1'h0, 12'h020, 32'h0);
		cmp(rd, 32'hA, "answer map");
		cmp(host_q.size(), 32'h3, "report length");
		cmp({8'h00, host_q[0], host_q[1], host_q[2]}, 32'h00303254, "report");
		cmp({irq, net_ok}, 2'h2, "irq set");
		apb(1'h1, 12'h014, 32'h0);
		@(posedge core_clk);
		cmp(irq, 1'h0, "irq masked");
		apb(1'h1, 12'h014, 32'h1);
		@(posedge core_clk);
		cmp(irq, 1'h1, "irq unmasked");
		apb(1'h1, 12'h010, 32'hF);
		@(posedge core_clk);
		cmp(irq, 1'h0, "irq cleared");
		$display("t_poll done");
	endtask
	task automatic t_fwd();
		send_frame(1'h0, 16'h3033);
		wait_frames(16'h4, "forward");
		cmp(last_addr, 7'h03, "forward addr");
		for (int i = 0; i < 3; i++) begin
			send_frame(1'h0, bad[i]);
			wait_frames(16'h4, "dropped");
			apb(1'h0, 12'h010, 32'h0);
			cmp(rd[2], 1'h1, "drop flag");
			apb(1'h1, 12'h010, 32'hF);
		end
		$display("t_fwd done");
	endtask
	task automatic t_svc();
		// a stray start on the service port must not open a frame
		tx_byte(1'h1, 8'h02);
		send_frame(1'h0, 16'h3033);
		wait_frames(16'h5, "svc blocked");
		svc_sw <= 1'h1;
		repeat (4) @(posedge core_clk);
		apb(1'h0, 12'h00C, 32'h0);
		cmp(rd[1], 1'h1, "svc mode");
		send_frame(1'h0, 16'h3033);
		wait_frames(16'h5, "host cut");
		svc_sw <= 1'h0;
		repeat (8) @(posedge core_clk);
		send_frame(1'h0, 16'h3031);
		wait_frames(16'h6, "host back");
		cmp(last_addr, 7'h01, "host back addr");
		$display("t_svc done");
	endtask
	initial begin
		resetn = 1'h0;
		{psel, penable, pwrite, svc_sw} = 4'h0;
		{host_rxd, svc_rxd} = 2'h3;
		paddr = 12'h0;
		pwdata = 32'h0;
		addr_sw = 7'h0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'h1;
		t_regs();
		t_poll();
		t_fwd();
		t_svc();
		wrap_up();
	end
endmodule
